// File: rtl/pwg_pkg.sv
// Purpose: shared constants and types of the pulse waveform generator
// Assumes: 40 MHz core clock, all times held as counts of 25 ns ticks
// Notes: long counts are only defaults here; the top module exposes them
`default_nettype none

package pwg_pkg;

  // widths
  localparam int TW = 37;
  localparam int DUW = 7;
  localparam int AW = 6;
  localparam int BW = 32;
  localparam int HW = TW - BW;
  localparam int NW = TW + DUW;

  // clock period and documented times in ns
  localparam longint CLK_NS = 64'h19;
  localparam longint PER_MIN_NS = 64'hC8;
  localparam longint PER_MAX_NS = 64'h1D1A94A2000;
  localparam longint PER_DEF_NS = 64'hF4240;
  localparam longint WID_DEF_NS = 64'h7A120;
  localparam longint WMIN0_NS = 64'h28;
  localparam longint WMIN1_NS = 64'hC8;
  localparam longint WMIN2_NS = 64'h7D0;
  localparam longint WMIN3_NS = 64'h4E20;
  localparam longint TIER1_NS = 64'h2540BE400;
  localparam longint TIER2_NS = 64'h174876E800;
  localparam longint TIER3_NS = 64'hE8D4A51000;

  // tick counts: least times round up, longest times round down
  localparam logic [TW-1:0] PER_MIN_CYC = TW'((PER_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TW-1:0] PER_MAX_CYC_D = TW'(PER_MAX_NS / CLK_NS);
  localparam logic [TW-1:0] PER_DEF_CYC_D = TW'(PER_DEF_NS / CLK_NS);
  localparam logic [TW-1:0] WID_DEF_CYC_D = TW'(WID_DEF_NS / CLK_NS);
  localparam logic [TW-1:0] WMIN0_CYC = TW'((WMIN0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TW-1:0] WMIN1_CYC = TW'((WMIN1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TW-1:0] WMIN2_CYC = TW'((WMIN2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TW-1:0] WMIN3_CYC = TW'((WMIN3_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TW-1:0] TIER1_CYC_D = TW'(TIER1_NS / CLK_NS);
  localparam logic [TW-1:0] TIER2_CYC_D = TW'(TIER2_NS / CLK_NS);
  localparam logic [TW-1:0] TIER3_CYC_D = TW'(TIER3_NS / CLK_NS);

  // duty cycle in whole percent
  localparam logic [DUW-1:0] DUTY_DEF = 7'h32;
  localparam logic [DUW-1:0] DUTY_LO = 7'h01;
  localparam logic [DUW-1:0] DUTY_HI = 7'h63;
  localparam logic [DUW-1:0] PCT = 7'h64;

  // register byte offsets
  localparam logic [AW-1:0] REG_CTRL = 6'h00;
  localparam logic [AW-1:0] REG_STAT = 6'h04;
  localparam logic [AW-1:0] REG_PER_LO = 6'h08;
  localparam logic [AW-1:0] REG_PER_HI = 6'h0C;
  localparam logic [AW-1:0] REG_WID_LO = 6'h10;
  localparam logic [AW-1:0] REG_WID_HI = 6'h14;
  localparam logic [AW-1:0] REG_DUTY = 6'h18;
  localparam logic [AW-1:0] REG_IRQ_STAT = 6'h1C;
  localparam logic [AW-1:0] REG_IRQ_MASK = 6'h20;
  localparam logic [AW-1:0] REG_WMIN = 6'h24;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_APPLY_BIT = 1;
  localparam int ST_GATE_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_OVL_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int IRQ_OVL_BIT = 0;
  localparam int IRQ_ADJ_BIT = 1;
  localparam int IRQ_DONE_BIT = 2;

  typedef enum logic [1:0] {
    UPD_IDLE = 2'h0,
    UPD_DIV1 = 2'h1,
    UPD_CLAMP = 2'h3,
    UPD_DIV2 = 2'h2
  } pwg_upd_t;

endpackage

`default_nettype wire

// File: rtl/pwg_sync.sv
// Purpose: two-stage synchroniser for a level arriving from a pin
// Assumes: input is asynchronous to core_clk
// Notes: the first stage feeds only the second
`default_nettype none

module pwg_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire

// File: rtl/pwg_div.sv
// Purpose: sequential restoring divider, one quotient bit per clock
// Assumes: denominator nonzero; start only while not busy
// Notes: done pulses one cycle, NUM_W cycles after start
`default_nettype none

module pwg_div #(
  parameter int NUM_W = 44,
  parameter int DEN_W = 37
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // request
  input wire logic start,
  input wire logic [NUM_W-1:0] numer,
  input wire logic [DEN_W-1:0] denom,
  // answer
  output logic done,
  output logic [NUM_W-1:0] quot
);

  localparam int CW = $clog2(NUM_W + 1);

  logic [DEN_W-1:0] rem_r;
  logic [DEN_W-1:0] den_r;
  logic [NUM_W-1:0] quo_r;
  logic [CW-1:0] cnt_r;
  logic run_r;
  logic done_r;
  logic [DEN_W:0] shift_val;
  logic fits;

  assign shift_val = {rem_r, quo_r[NUM_W-1]};
  assign fits = shift_val >= {1'b0, den_r};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rem_r <= '0;
      den_r <= '0;
      quo_r <= '0;
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        rem_r <= '0;
        den_r <= denom;
        quo_r <= numer;
        cnt_r <= CW'(NUM_W);
        run_r <= 1'b1;
      end else if (run_r) begin
        rem_r <= fits ? DEN_W'(shift_val - {1'b0, den_r}) : DEN_W'(shift_val);
        quo_r <= {quo_r[NUM_W-2:0], fits};
        cnt_r <= cnt_r - CW'(1);
        if (cnt_r == CW'(1)) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign done = done_r;
  assign quot = quo_r;

endmodule

`default_nettype wire

// File: rtl/pwg_top.sv
// Purpose: pulse timing core with output gate, register port and interrupt
// Assumes: one 40 MHz clock, synchronous active-high reset, overload pin async
// Notes: period and width in 25 ns ticks; duty in whole percent
//
// The plain strobed port and the address map were left to the implementer.
`default_nettype none

// Contract
// - output gate is off after reset until software enables it
// - overload forces the gate off; re-enable needs overload gone plus new enable
// - apply command commits the staged period and forces the gate on
// - period clamps to 200 ns .. 2000 s, default 1 ms
// - a new period readjusts the stored width to stay legal
// - width spans rising output edge to following falling edge
// - width spans 40 ns to below 2000 s, default 500 us
// - minimum width steps 40 ns, 200 ns, 2 us, 20 us with period
// - width never exceeds period minus the minimum width
// - duty is 100 times width over period, kept within 1..99, default 50
// - duty clamped between minimum width and period minus minimum, as percent
module pwg_top
  import pwg_pkg::*;
#(
  parameter logic [TW-1:0] PER_MAX_CYC = PER_MAX_CYC_D,
  parameter logic [TW-1:0] PER_DEF_CYC = PER_DEF_CYC_D,
  parameter logic [TW-1:0] WID_DEF_CYC = WID_DEF_CYC_D,
  parameter logic [TW-1:0] TIER1_CYC = TIER1_CYC_D,
  parameter logic [TW-1:0] TIER2_CYC = TIER2_CYC_D,
  parameter logic [TW-1:0] TIER3_CYC = TIER3_CYC_D
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [BW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [BW-1:0] rd_data,
  // output connector
  input wire logic ovl_in,
  output logic pulse_out,
  output logic gate_on,
  // interrupt
  output logic irq
);

  // overload synchroniser
  logic ovl_s;
  logic ovl_d_r;

  // gate
  logic gate_r;

  // settings
  pwg_upd_t state_r;
  logic [TW-1:0] per_r;
  logic [TW-1:0] wid_r;
  logic [DUW-1:0] duty_r;
  logic [TW-1:0] per_stage_r;
  logic [TW-1:0] wid_stage_r;
  logic [TW-1:0] wid_cand_r;

  // divider
  logic div_start_r;
  logic [NW-1:0] div_num_r;
  logic [TW-1:0] div_den_r;
  logic div_done;
  logic [NW-1:0] div_quot;

  // interrupt and read path
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic irq_r;
  logic [BW-1:0] rd_data_r;
  logic [BW-1:0] rd_mux;

  // pulse generator
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] act_per_r;
  logic [TW-1:0] act_wid_r;
  logic pulse_r;

  // decodes and combinational helpers
  logic upd_idle;
  logic ctrl_wr;
  logic apply_cmd;
  logic per_lo_wr;
  logic per_cmd;
  logic wid_cmd;
  logic duty_cmd;
  logic [TW-1:0] per_new;
  logic [TW-1:0] per_clamped;
  logic [TW-1:0] wmin;
  logic [TW-1:0] wid_max;
  logic [TW-1:0] wid_clamped;
  logic [DUW-1:0] duty_in;
  logic [DUW-1:0] duty_clamped;
  logic [DUW-1:0] duty_res;
  logic ovl_ev;
  logic adj_ev;
  logic done_ev;
  logic [IRQ_W-1:0] irq_ev;

  pwg_sync u_ovl_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in(ovl_in),
    .sync_out(ovl_s)
  );

  pwg_div #(
    .NUM_W(NW),
    .DEN_W(TW)
  ) u_div (
    .core_clk(core_clk),
    .reset(reset),
    .start(div_start_r),
    .numer(div_num_r),
    .denom(div_den_r),
    .done(div_done),
    .quot(div_quot)
  );

  // register decodes
  assign upd_idle = state_r == UPD_IDLE;
  assign ctrl_wr = wr_en && addr == REG_CTRL;
  assign apply_cmd = ctrl_wr && wr_data[CTRL_APPLY_BIT];
  assign per_lo_wr = wr_en && addr == REG_PER_LO;
  // settings writes landing while an update is running are dropped
  assign per_cmd = upd_idle && (per_lo_wr || apply_cmd);
  assign wid_cmd = upd_idle && wr_en && addr == REG_WID_LO;
  assign duty_cmd = upd_idle && wr_en && addr == REG_DUTY;
  assign per_new = per_lo_wr ? {per_stage_r[TW-1:BW], wr_data} : per_stage_r;

  // period range
  always_comb begin
    if (per_new < PER_MIN_CYC) begin
      per_clamped = PER_MIN_CYC;
    end else if (per_new > PER_MAX_CYC) begin
      per_clamped = PER_MAX_CYC;
    end else begin
      per_clamped = per_new;
    end
  end

  // minimum width steps with the period in force
  always_comb begin
    if (per_r <= TIER1_CYC) begin
      wmin = WMIN0_CYC;
    end else if (per_r <= TIER2_CYC) begin
      wmin = WMIN1_CYC;
    end else if (per_r <= TIER3_CYC) begin
      wmin = WMIN2_CYC;
    end else begin
      wmin = WMIN3_CYC;
    end
  end

  // width window; the low phase never drops under the minimum either
  assign wid_max = per_r - wmin;
  always_comb begin
    if (wid_cand_r < wmin) begin
      wid_clamped = wmin;
    end else if (wid_cand_r > wid_max) begin
      wid_clamped = wid_max;
    end else begin
      wid_clamped = wid_cand_r;
    end
  end

  // duty written by software and duty recomputed from width
  assign duty_in = wr_data[DUW-1:0];
  always_comb begin
    if (wr_data > BW'(DUTY_HI)) begin
      duty_clamped = DUTY_HI;
    end else if (duty_in < DUTY_LO) begin
      duty_clamped = DUTY_LO;
    end else begin
      duty_clamped = duty_in;
    end
  end
  // truncated percent can read 0 at long periods, so it is held to 1..99
  always_comb begin
    if (div_quot < NW'(DUTY_LO)) begin
      duty_res = DUTY_LO;
    end else if (div_quot > NW'(DUTY_HI)) begin
      duty_res = DUTY_HI;
    end else begin
      duty_res = div_quot[DUW-1:0];
    end
  end

  // overload edge detect
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ovl_d_r <= 1'b0;
    end else begin
      ovl_d_r <= ovl_s;
    end
  end

  // output gate
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gate_r <= 1'b0;
    end else if (ovl_s) begin
      gate_r <= 1'b0;
    end else if (apply_cmd) begin
      gate_r <= 1'b1;
    end else if (ctrl_wr) begin
      gate_r <= wr_data[CTRL_EN_BIT];
    end
  end

  // staging halves of period and width
  always_ff @(posedge core_clk) begin
    if (reset) begin
      per_stage_r <= PER_DEF_CYC;
      wid_stage_r <= WID_DEF_CYC;
    end else if (wr_en) begin
      if (addr == REG_PER_HI) begin
        per_stage_r[TW-1:BW] <= wr_data[HW-1:0];
      end
      if (addr == REG_PER_LO) begin
        per_stage_r[BW-1:0] <= wr_data;
      end
      if (addr == REG_WID_HI) begin
        wid_stage_r[TW-1:BW] <= wr_data[HW-1:0];
      end
      if (addr == REG_WID_LO) begin
        wid_stage_r[BW-1:0] <= wr_data;
      end
    end
  end

  // settings update sequence
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= UPD_IDLE;
      per_r <= PER_DEF_CYC;
      wid_r <= WID_DEF_CYC;
      duty_r <= DUTY_DEF;
      wid_cand_r <= WID_DEF_CYC;
      div_start_r <= 1'b0;
      div_num_r <= '0;
      div_den_r <= PER_DEF_CYC;
    end else begin
      div_start_r <= 1'b0;
      case (state_r)
        UPD_IDLE: begin
          if (per_cmd) begin
            per_r <= per_clamped;
            wid_cand_r <= wid_r;
            state_r <= UPD_CLAMP;
          end else if (wid_cmd) begin
            wid_cand_r <= {wid_stage_r[TW-1:BW], wr_data};
            state_r <= UPD_CLAMP;
          end else if (duty_cmd) begin
            div_num_r <= NW'(per_r) * NW'(duty_clamped);
            div_den_r <= TW'(PCT);
            div_start_r <= 1'b1;
            state_r <= UPD_DIV1;
          end
        end
        UPD_DIV1: begin
          if (div_done) begin
            wid_cand_r <= div_quot[TW-1:0];
            state_r <= UPD_CLAMP;
          end
        end
        UPD_CLAMP: begin
          wid_r <= wid_clamped;
          div_num_r <= NW'(wid_clamped) * NW'(PCT);
          div_den_r <= per_r;
          div_start_r <= 1'b1;
          state_r <= UPD_DIV2;
        end
        UPD_DIV2: begin
          if (div_done) begin
            duty_r <= duty_res;
            state_r <= UPD_IDLE;
          end
        end
        default: begin
          state_r <= UPD_IDLE;
        end
      endcase
    end
  end

  // interrupt events
  assign ovl_ev = ovl_s && !ovl_d_r;
  assign adj_ev = (per_cmd && per_clamped != per_new)
               || (duty_cmd && duty_clamped != duty_in)
               || (state_r == UPD_CLAMP && wid_clamped != wid_cand_r);
  assign done_ev = state_r == UPD_DIV2 && div_done;
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_OVL_BIT] = ovl_ev;
    irq_ev[IRQ_ADJ_BIT] = adj_ev;
    irq_ev[IRQ_DONE_BIT] = done_ev;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_stat_r <= '0;
    end else if (wr_en && addr == REG_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~wr_data[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_mask_r <= '0;
    end else if (wr_en && addr == REG_IRQ_MASK) begin
      irq_mask_r <= wr_data[IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    case (addr)
      REG_CTRL: rd_mux[CTRL_EN_BIT] = gate_r;
      REG_STAT: begin
        rd_mux[ST_GATE_BIT] = gate_r;
        rd_mux[ST_BUSY_BIT] = !upd_idle;
        rd_mux[ST_OVL_BIT] = ovl_s;
      end
      REG_PER_LO: rd_mux = per_r[BW-1:0];
      REG_PER_HI: rd_mux[HW-1:0] = per_r[TW-1:BW];
      REG_WID_LO: rd_mux = wid_r[BW-1:0];
      REG_WID_HI: rd_mux[HW-1:0] = wid_r[TW-1:BW];
      REG_DUTY: rd_mux[DUW-1:0] = duty_r;
      REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_r;
      REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
      REG_WMIN: rd_mux = wmin[BW-1:0];
      default: rd_mux = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data_r <= '0;
    end else if (rd_en) begin
      rd_data_r <= rd_mux;
    end else begin
      rd_data_r <= '0;
    end
  end

  // pulse counter; new settings are taken at a period boundary so that
  // no runt pulse is produced, at the cost of up to one period of delay
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= '0;
      act_per_r <= PER_DEF_CYC;
      act_wid_r <= WID_DEF_CYC;
    end else if (!gate_r || cnt_r == act_per_r - TW'(1)) begin
      cnt_r <= '0;
      if (upd_idle) begin
        act_per_r <= per_r;
        act_wid_r <= wid_r;
      end
    end else begin
      cnt_r <= cnt_r + TW'(1);
    end
  end

  // high from the rising edge for exactly the width count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= gate_r && cnt_r < act_wid_r;
    end
  end

  assign rd_data = rd_data_r;
  assign pulse_out = pulse_r;
  assign gate_on = gate_r;
  assign irq = irq_r;

endmodule

`default_nettype wire

// File: tb/pwg_load.sv
// Purpose: external load on the waveform connector, able to apply an overload
// Assumes: trip is a level from the bench; the overload is asynchronous to the core
// Notes: DLY_NS sets how late the overload reaches the sense line
`default_nettype none

module pwg_load #(
  parameter int DLY_NS = 7
) (
  // bench command
  input wire logic trip,
  // sense line into the device
  output logic ovl_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial ovl_in = 1'b0;
  // overload held for as long as the bench trips it, removed only on release
  always @(trip) ovl_in <= #(DLY_NS) trip;
endmodule

`default_nettype wire

// File: tb/pwg_top_sva.sv
// Purpose: port-level checks of the pulse generator top
// Assumes: bound to pwg_top, one clock, synchronous active-high reset
// Notes: register reads are judged in the cycle after the strobe
`default_nettype none

module pwg_top_sva
  import pwg_pkg::*;
#(
  parameter logic [TW-1:0] PER_MAX_CYC = PER_MAX_CYC_D
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [BW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [BW-1:0] rd_data,
  // connector and interrupt
  input wire logic ovl_in,
  input wire logic pulse_out,
  input wire logic gate_on,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_gate_reset: assert property ($fell(reset) |-> !gate_on)
    else $error("gate on right after reset");
  a_gate_cause: assert property ($rose(gate_on) |->
    $past(wr_en && addr == REG_CTRL && wr_data[1:0] != 2'h0))
    else $error("gate rose without enable or apply");
  a_ovl_off: assert property (ovl_in [*5] |-> !gate_on)
    else $error("gate on during overload");
  a_pulse_gated: assert property (!gate_on [*2] |-> !pulse_out)
    else $error("pulse with gate off");
  a_high_min: assert property ($rose(pulse_out) && gate_on |=> pulse_out || !gate_on)
    else $error("high phase below minimum");
  a_low_min: assert property ($fell(pulse_out) && gate_on |=> !pulse_out)
    else $error("low phase below minimum");
  a_wmin_set: assert property (rd_en && addr == REG_WMIN |=>
    rd_data inside {32'h2, 32'h8, 32'h50, 32'h320})
    else $error("minimum width off the table");
  a_per_range: assert property (rd_en && addr == REG_PER_LO |=>
    rd_data >= 32'h8 && rd_data <= BW'(PER_MAX_CYC))
    else $error("period out of range");
  a_duty_range: assert property (rd_en && addr == REG_DUTY |=>
    rd_data inside {[32'h1:32'h63]})
    else $error("duty out of range");
  a_unmapped_zero: assert property (rd_en && addr == 6'h28 |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (wr_en && addr == REG_IRQ_MASK && wr_data[2:0] == 3'h0
    |=> ##1 !irq)
    else $error("irq with all masked");

  c_gate_rise: cover property ($rose(gate_on));
  c_ovl_trip: cover property (ovl_in [*5] ##1 !gate_on);
  c_irq_rise: cover property ($rose(irq));
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench of the pulse generator top
// Assumes: shortened tier and period parameters, 40 MHz clock
// Notes: tier 3 is moved up so its minimum width fits inside the period
`default_nettype none

module tb_top
  import pwg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T1 = 100;
  localparam int T2 = 200;
  localparam int T3 = 1600;
  localparam int PMAX = 2000;
  logic core_clk, reset, wr_en, rd_en, ovl_in, pulse_out, gate_on, irq, trip;
  logic [AW-1:0] addr;
  logic [BW-1:0] wr_data, rd_data, got;
  int n_fail, samples_checked, seed, per, wid, duty, v, i, hi, lo;
  int pt[10] = '{5, 8, 100, 101, 200, 201, 1600, 1601, 2000, 2500};
  int dt[6] = '{0, 1, 50, 99, 100, 127};

  pwg_top #(.PER_MAX_CYC(TW'(PMAX)), .PER_DEF_CYC(37'h28), .WID_DEF_CYC(37'h14),
    .TIER1_CYC(TW'(T1)), .TIER2_CYC(TW'(T2)), .TIER3_CYC(TW'(T3))) u_dut (
    .core_clk(core_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ovl_in(ovl_in),
    .pulse_out(pulse_out), .gate_on(gate_on), .irq(irq));
  pwg_load u_load (.trip(trip), .ovl_in(ovl_in));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  function automatic int wmin_f(int p);
    if (p <= T1) return 2;
    if (p <= T2) return 8;
    if (p <= T3) return 80;
    return 800;
  endfunction
  function automatic int lim(int x, int a, int b);
    return (x < a) ? a : ((x > b) ? b : x);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [BW-1:0] e, input logic [BW-1:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input int d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= BW'(d);
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    got = rd_data;
  endtask
  task automatic rdchk(input string nm, input logic [AW-1:0] a, input int e);
    rd(a);
    chk(nm, BW'(e), got);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 100; k++) begin
      rd(REG_STAT);
      if (got[ST_BUSY_BIT] === 1'b0) return;
    end
    chk("busy", 0, 1);
  endtask
  task automatic wait_lvl(input logic l);
    for (int k = 0; k < 5000; k++) begin
      @(negedge core_clk);
      if (pulse_out === l) return;
    end
    chk("pulse_level", l, ~l);
  endtask
  // first full period after the call is timed, so new settings have surely taken effect
  task automatic measure();
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    for (hi = 1; hi < 5000; hi++) begin
      @(negedge core_clk);
      if (pulse_out !== 1'b1) break;
    end
    for (lo = 1; lo < 5000; lo++) begin
      @(negedge core_clk);
      if (pulse_out !== 1'b0) break;
    end
    chk("high_ticks", wid, hi);
    chk("low_ticks", per - wid, lo);
  endtask
  task automatic check_all();
    duty = lim(100 * wid / per, 1, 99);
    rdchk("period", REG_PER_LO, per);
    rdchk("period_hi", REG_PER_HI, 0);
    rdchk("width", REG_WID_LO, wid);
    rdchk("width_hi", REG_WID_HI, 0);
    rdchk("duty", REG_DUTY, duty);
    rdchk("wmin", REG_WMIN, wmin_f(per));
  endtask
  task automatic gate_is(input logic e);
    idle(1);
    chk("gate", e, gate_on);
  endtask

  initial begin
    seed = 36;
    {wr_en, rd_en, trip} = 3'h0;
    reset = 1'b1;
    addr = '0;
    wr_data = '0;
    per = 40;
    wid = 20;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    idle(40);
    chk("gate", 0, gate_on);
    chk("pulse", 0, pulse_out);
    rdchk("ctrl", REG_CTRL, 0);
    rdchk("unmapped", 6'h28, 0);
    check_all();
    wr(REG_CTRL, 1);
    gate_is(1'b1);
    measure();
    for (i = 0; i < 14; i++) begin
      v = (i < 10) ? pt[i] : 8 + ($random(seed) & 32'h7FF);
      wr(REG_PER_HI, 0);
      wr(REG_PER_LO, v);
      // a duty write landing while busy must be ignored
      if (i == 3) wr(REG_DUTY, 77);
      per = lim(v, 8, PMAX);
      wid = lim(wid, wmin_f(per), per - wmin_f(per));
      wait_idle();
      check_all();
      if (i % 4 == 0) measure();
    end
    wr(REG_PER_LO, 300);
    per = 300;
    wid = lim(wid, 80, 220);
    wait_idle();
    for (i = 0; i < 10; i++) begin
      v = (i < 6) ? dt[i] : ($random(seed) & 32'h7F);
      wr(REG_IRQ_STAT, 7);
      wr(REG_DUTY, v);
      wid = lim(per * lim(v, 1, 99) / 100, 80, 220);
      wait_idle();
      check_all();
      // done always lands; adjusted only when duty or the width from it was clamped
      hi = (v != lim(v, 1, 99) || wid != per * lim(v, 1, 99) / 100) ? 6 : 4;
      rdchk("irq_stat", REG_IRQ_STAT, hi);
    end
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 0 : ($random(seed) & 32'h1FF);
      wr(REG_WID_HI, 0);
      wr(REG_WID_LO, v);
      wid = lim(v, 80, 220);
      wait_idle();
      check_all();
    end
    measure();
    wr(REG_IRQ_STAT, 7);
    wr(REG_IRQ_MASK, 1);
    idle(2);
    chk("irq", 0, irq);
    rdchk("irq_mask", REG_IRQ_MASK, 1);
    @(posedge core_clk);
    trip <= 1'b1;
    idle(8);
    chk("gate", 0, gate_on);
    rdchk("status", REG_STAT, 4);
    chk("irq", 1, irq);
    rdchk("irq_stat", REG_IRQ_STAT, 1);
    wr(REG_IRQ_MASK, 0);
    idle(2);
    chk("irq", 0, irq);
    wr(REG_IRQ_MASK, 1);
    idle(2);
    chk("irq", 1, irq);
    wr(REG_IRQ_STAT, 1);
    idle(2);
    chk("irq", 0, irq);
    wr(REG_CTRL, 1);
    gate_is(1'b0);
    wr(REG_CTRL, 2);
    gate_is(1'b0);
    @(posedge core_clk);
    trip <= 1'b0;
    idle(8);
    chk("gate", 0, gate_on);
    wr(REG_CTRL, 1);
    gate_is(1'b1);
    wr(REG_CTRL, 0);
    gate_is(1'b0);
    wr(REG_CTRL, 2);
    gate_is(1'b1);
    wait_idle();
    check_all();
    measure();
    summarize();
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    summarize();
  end
endmodule

bind pwg_top pwg_top_sva #(.PER_MAX_CYC(PER_MAX_CYC)) u_sva (
  .core_clk(core_clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .ovl_in(ovl_in), .pulse_out(pulse_out),
  .gate_on(gate_on), .irq(irq));

`default_nettype wire
